// ### src/cmp_timer_pkg.sv
// Package with register map, field layouts, reset values and clock source codes for the timer.
package cmp_timer_pkg;

  // Register byte addresses on the APB bus (one aligned word each).
  localparam logic [7:0] OFS_COUNT_HI = 8'h00;
  localparam logic [7:0] OFS_COUNT_LO = 8'h04;
  localparam logic [7:0] OFS_COMPARE_HI = 8'h08;
  localparam logic [7:0] OFS_COMPARE_LO = 8'h0C;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h10;
  localparam logic [7:0] OFS_FLAG_CTRL = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  // Reset values.
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hFFFF;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;

  // Counter values that mark a wrap.
  localparam logic [15:0] TOP16 = 16'hFFFF;
  localparam logic [7:0] TOP8 = 8'hFF;

  // Internal clock codes in the low two bits of a clock select field.
  localparam logic [1:0] SEL_DIV32 = 2'h0;
  localparam logic [1:0] SEL_DIV16 = 2'h1;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
  localparam logic [1:0] SEL_WATCH4 = 2'h3;

  // Prescaler terminal counts for each divided clock.
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // Bit positions inside the config register.
  localparam int CFG_IRQ_EN_HI = 0;
  localparam int CFG_IRQ_EN_LO = 1;
  localparam int CFG_EDGE_SEL = 2;
  localparam int CFG_LOW_SPEED = 3;

  // Clock control register: bit 2 of hi_clock_select (register bit 6) is the width select bit.
  typedef struct packed {
    logic out_level_hi;
    logic [2:0] hi_clock_select;
    logic out_level_lo;
    logic [2:0] lo_clock_select;
  } clock_ctrl_t;

  // Flag and control register, bit 7 down to bit 0.
  typedef struct packed {
    logic wrap_flag_hi;
    logic match_flag_hi;
    logic wrap_irq_en_hi;
    logic match_clear_hi;
    logic wrap_flag_lo;
    logic match_flag_lo;
    logic wrap_irq_en_lo;
    logic match_clear_lo;
  } flag_ctrl_t;

endpackage

// ### src/dual_mode_compare_timer.sv
// Dual mode compare timer: one 16-bit or two 8-bit counters behind an APB slave.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none

module dual_mode_compare_timer #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources.
  input wire logic watch_tick,
  input wire logic event_pin,
  // Pins and interrupt requests.
  output logic toggle_pin_hi,
  output logic toggle_pin_lo,
  output logic irq_hi,
  output logic irq_lo
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic [15:0] cnt_ff; // Live counter, halves are count_hi and count_lo.
  logic [15:0] cmp_ff; // Compare value.
  logic [7:0] latch_ff; // Byte latch shared by all 16-bit accesses except compare reads.
  cmp_timer_pkg::clock_ctrl_t ctrl_ff; // Clock control register.
  cmp_timer_pkg::flag_ctrl_t flag_ff; // Flag and control register.
  logic [7:0] cfg_ff; // Interrupt enables, edge select, low speed mode.
  logic [7:0] armed_ff; // Flags read as one, eligible for clearing.
  logic [4:0] pre_ff; // Free running prescaler.
  logic [1:0] wdiv_ff; // Watch clock divider.
  logic event_prev_ff; // Previous event pin level.
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic tog_hi_ff;
  logic tog_lo_ff;
  logic irq_hi_ff;
  logic irq_lo_ff;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign toggle_pin_hi = tog_hi_ff;
  assign toggle_pin_lo = tog_lo_ff;
  assign irq_hi = irq_hi_ff;
  assign irq_lo = irq_lo_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock sources.

  // Picks the tick of one internal clock; in low speed mode only the watch clock runs.
  function automatic logic sel_tick(input logic [1:0] sel, input logic [4:0] pre,
                                    input logic wtick, input logic low_speed);
    logic t;
    t = 1'b0;
    unique case (sel)
      cmp_timer_pkg::SEL_DIV32: t = (pre == cmp_timer_pkg::DIV32_LAST) && !low_speed;
      cmp_timer_pkg::SEL_DIV16: t = (pre[3:0] == cmp_timer_pkg::DIV16_LAST) && !low_speed;
      cmp_timer_pkg::SEL_DIV4: t = (pre[1:0] == cmp_timer_pkg::DIV4_LAST) && !low_speed;
      cmp_timer_pkg::SEL_WATCH4: t = wtick;
    endcase
    return t;
  endfunction

  // Prescaler and watch divider run all the time so selections switch cleanly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 5'h00;
      wdiv_ff <= 2'h0;
      event_prev_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 5'h01;
      if (watch_tick) begin
        wdiv_ff <= wdiv_ff + 2'h1;
      end
      event_prev_ff <= event_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic acc;
  logic rd_setup;
  logic wr_cnt_hi, wr_cnt_lo, wr_cmp_hi, wr_cmp_lo, wr_ctrl, wr_flag, wr_cfg;
  logic rd_cnt_hi, rd_cnt_lo, rd_flag;
  logic mode8;
  logic [7:0] wd;

  // Writes act at the access edge; reads act at the setup edge so data is ready.
  assign acc = psel && penable && pready_ff;
  assign rd_setup = psel && !penable && !pwrite;
  assign wd = pwdata[7:0];
  assign mode8 = ctrl_ff.hi_clock_select[2];
  assign wr_cnt_hi = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_HI));
  assign wr_cnt_lo = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_LO));
  assign wr_cmp_hi = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COMPARE_HI));
  assign wr_cmp_lo = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COMPARE_LO));
  assign wr_ctrl = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_CLOCK_CTRL));
  assign wr_flag = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_FLAG_CTRL));
  assign wr_cfg = acc && pwrite && (paddr == ADDR_W'(cmp_timer_pkg::OFS_CONFIG));
  assign rd_cnt_hi = rd_setup && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_HI));
  assign rd_cnt_lo = rd_setup && (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_LO));
  assign rd_flag = rd_setup && (paddr == ADDR_W'(cmp_timer_pkg::OFS_FLAG_CTRL));

  ////////////////////////////////////////////////////////////////////////////////
  // Counting, matches and wraps.
  logic tick_lo, tick_hi, ev_tick;
  logic [15:0] cmp_eff;
  logic [15:0] nxt_cnt;
  logic match_hi, match_lo, wrap_hi, wrap_lo;

  // Selected edge of the event pin; the source must hold each level one clock.
  assign ev_tick = cfg_ff[cmp_timer_pkg::CFG_EDGE_SEL] ? (event_pin && !event_prev_ff)
                                                       : (!event_pin && event_prev_ff);

  always_comb begin
    // Lower half (or the whole 16-bit counter) follows lo_clock_select.
    tick_lo = ctrl_ff.lo_clock_select[2]
            ? sel_tick(ctrl_ff.lo_clock_select[1:0], pre_ff,
                       watch_tick && (wdiv_ff == cmp_timer_pkg::DIV4_LAST),
                       cfg_ff[cmp_timer_pkg::CFG_LOW_SPEED])
            : (ev_tick && !cfg_ff[cmp_timer_pkg::CFG_LOW_SPEED]);
    tick_hi = mode8 && sel_tick(ctrl_ff.hi_clock_select[1:0], pre_ff,
                                watch_tick && (wdiv_ff == cmp_timer_pkg::DIV4_LAST),
                                cfg_ff[cmp_timer_pkg::CFG_LOW_SPEED]);
    // A compare write now (either byte in 8-bit mode, the lower byte in 16-bit mode) is compared at once, so only an equal value matches.
    cmp_eff = cmp_ff;
    if (!mode8 && wr_cmp_lo) begin
      cmp_eff = {latch_ff, wd};
    end else if (mode8 && wr_cmp_hi) begin
      cmp_eff[15:8] = wd;
    end else if (mode8 && wr_cmp_lo) begin
      cmp_eff[7:0] = wd;
    end
    nxt_cnt = cnt_ff;
    match_hi = 1'b0;
    match_lo = 1'b0;
    wrap_hi = 1'b0;
    wrap_lo = 1'b0;
    if (!mode8) begin
      // The match is seen on the tick that leaves the equal value.
      match_hi = tick_lo && !wr_cnt_lo && (cnt_ff == cmp_eff);
      match_lo = tick_lo && !wr_cnt_lo && (cnt_ff[7:0] == cmp_eff[7:0]);
      // A write to the lower byte suppresses any wrap in that cycle.
      wrap_hi = tick_lo && !wr_cnt_lo && (cnt_ff == cmp_timer_pkg::TOP16) &&
                !(match_hi && flag_ff.match_clear_hi);
      wrap_lo = tick_lo && !wr_cnt_lo && (cnt_ff[7:0] == cmp_timer_pkg::TOP8) &&
                !(match_hi && flag_ff.match_clear_hi);
      if (wr_cnt_lo) begin
        nxt_cnt = {latch_ff, wd};
      end else if (match_hi && flag_ff.match_clear_hi) begin
        nxt_cnt = cmp_timer_pkg::RST_COUNT;
      end else if (tick_lo) begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else begin
      // Two independent halves, each with its own clear and wrap.
      match_hi = tick_hi && !wr_cnt_hi && (cnt_ff[15:8] == cmp_eff[15:8]);
      match_lo = tick_lo && !wr_cnt_lo && (cnt_ff[7:0] == cmp_eff[7:0]);
      wrap_hi = tick_hi && !wr_cnt_hi && (cnt_ff[15:8] == cmp_timer_pkg::TOP8) &&
                !(match_hi && flag_ff.match_clear_hi);
      wrap_lo = tick_lo && !wr_cnt_lo && (cnt_ff[7:0] == cmp_timer_pkg::TOP8) &&
                !(match_lo && flag_ff.match_clear_lo);
      if (wr_cnt_hi) begin
        nxt_cnt[15:8] = wd;
      end else if (match_hi && flag_ff.match_clear_hi) begin
        nxt_cnt[15:8] = cmp_timer_pkg::RST_COUNT[15:8];
      end else if (tick_hi) begin
        nxt_cnt[15:8] = cnt_ff[15:8] + 8'h01;
      end
      if (wr_cnt_lo) begin
        nxt_cnt[7:0] = wd;
      end else if (match_lo && flag_ff.match_clear_lo) begin
        nxt_cnt[7:0] = cmp_timer_pkg::RST_COUNT[7:0];
      end else if (tick_lo) begin
        nxt_cnt[7:0] = cnt_ff[7:0] + 8'h01;
      end
    end
  end

  // Counter register; upper byte writes in 16-bit mode leave it alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= cmp_timer_pkg::RST_COUNT;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte latch, compare, control and config registers.

  // One latch serves every 16-bit access except compare reads; 8-bit mode never touches it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= 8'h00;
    end else if (!mode8 && (wr_cnt_hi || wr_cmp_hi)) begin
      latch_ff <= wd;
    end else if (!mode8 && rd_cnt_hi) begin
      latch_ff <= cnt_ff[7:0];
    end
  end

  // Compare value: paired through the latch in 16-bit mode, direct in 8-bit mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ff <= cmp_timer_pkg::RST_COMPARE;
    end else begin
      cmp_ff <= cmp_eff;
    end
  end

  // Clock control and config registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= cmp_timer_pkg::RST_CTRL;
      cfg_ff <= cmp_timer_pkg::RST_CONFIG;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wd;
      end
      if (wr_cfg) begin
        cfg_ff <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags: hardware sets, software clears by reading one then writing zero.

  logic [7:0] set_mask;
  logic [7:0] clr_mask;

  assign set_mask = {wrap_hi, match_hi, 2'b00, wrap_lo, match_lo, 2'b00};
  assign clr_mask = (wr_flag ? ~wd : 8'h00) & armed_ff & 8'hCC;

  // Set wins over clear; writing one to a flag does nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= cmp_timer_pkg::RST_FLAG;
      armed_ff <= 8'h00;
    end else begin
      flag_ff <= ((flag_ff & ~clr_mask) | set_mask) & 8'hCC | (wr_flag ? wd & 8'h33
                                                                       : flag_ff & 8'h33);
      if (rd_flag) begin
        armed_ff <= flag_ff & 8'hCC;
      end else if (wr_flag) begin
        armed_ff <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Toggle pins and interrupt requests.

  // A control write sets the level and overrides a coincident toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_hi_ff <= 1'b0;
      tog_lo_ff <= 1'b0;
    end else if (wr_ctrl) begin
      tog_hi_ff <= wd[7];
      tog_lo_ff <= wd[3];
    end else begin
      tog_hi_ff <= tog_hi_ff ^ match_hi;
      tog_lo_ff <= tog_lo_ff ^ match_lo;
    end
  end

  // One-cycle request pulses; the wrap source needs its own enable too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_hi_ff <= 1'b0;
      irq_lo_ff <= 1'b0;
    end else begin
      irq_hi_ff <= cfg_ff[cmp_timer_pkg::CFG_IRQ_EN_HI] &&
                   (match_hi || (wrap_hi && flag_ff.wrap_irq_en_hi));
      irq_lo_ff <= cfg_ff[cmp_timer_pkg::CFG_IRQ_EN_LO] && mode8 &&
                   (match_lo || (wrap_lo && flag_ff.wrap_irq_en_lo));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait state, read data prepared at the setup edge.

  logic [31:0] nxt_rdata;
  logic nxt_err;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_HI)) begin
      nxt_rdata[7:0] = cnt_ff[15:8];
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_COUNT_LO)) begin
      nxt_rdata[7:0] = mode8 ? cnt_ff[7:0] : latch_ff;
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_COMPARE_HI)) begin
      nxt_rdata[7:0] = cmp_ff[15:8];
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_COMPARE_LO)) begin
      nxt_rdata[7:0] = cmp_ff[7:0];
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_CLOCK_CTRL)) begin
      nxt_rdata[7:0] = ctrl_ff;
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_FLAG_CTRL)) begin
      nxt_rdata[7:0] = flag_ff;
    end else if (paddr == ADDR_W'(cmp_timer_pkg::OFS_CONFIG)) begin
      nxt_rdata[7:0] = cfg_ff;
    end else begin
      nxt_err = 1'b1; // Unmapped address answers with an error and zero data.
    end
  end

  // Ready rises for exactly the one access cycle after each setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && !penable;
      if (psel && !penable) begin
        pslverr_ff <= nxt_err;
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  hi_write_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cnt_hi && !mode8 && !tick_lo) |=> (latch_ff == $past(wd)) && $stable(cnt_ff))
    else $error("Upper count write changed the counter.");
  lo_write_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cnt_lo && !mode8) |=> cnt_ff == {$past(latch_ff), $past(wd)})
    else $error("Lower count write did not load both bytes.");
  hi_read_snap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_cnt_hi && !mode8) |=> (latch_ff == $past(cnt_ff[7:0])) &&
                              (prdata_ff[7:0] == $past(cnt_ff[15:8])))
    else $error("Upper count read did not snapshot the lower byte.");
  lo_read_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_cnt_lo && !mode8) |=> prdata_ff[7:0] == $past(latch_ff))
    else $error("Lower count read did not return the latch.");
  match_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (match_hi && !mode8 && flag_ff.match_clear_hi) |=> cnt_ff == cmp_timer_pkg::RST_COUNT)
    else $error("Counter not cleared on match.");
  pin_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (match_hi && !wr_ctrl) |=> tog_hi_ff != $past(tog_hi_ff))
    else $error("Toggle pin did not invert on match.");
  ctrl_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (tog_hi_ff == $past(wd[7])) && (tog_lo_ff == $past(wd[3])))
    else $error("Control write did not set the pin level.");
  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_hi |=> flag_ff.wrap_flag_hi ##1 (flag_ff.wrap_flag_hi || $past(wr_flag)))
    else $error("Wrap flag not held after wrap.");
  flag_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && !match_hi && !flag_ff.match_flag_hi) |=> !flag_ff.match_flag_hi)
    else $error("Software managed to set a match flag.");
  cmp_suppress_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode8 && wr_cmp_lo && (wd != cnt_ff[7:0])) |-> !match_lo)
    else $error("Match seen during compare write with unequal value.");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready_ff ##1 !pready_ff || (psel && !penable))
    else $error("Ready did not answer the setup cycle.");
endmodule

`default_nettype wire

// ### testbench/apb_cpu_model.sv
// CPU-side APB master model that drives the timer's register bus.
`timescale 1ns/10ps
`default_nettype none
module apb_cpu_model #(
  parameter int ADDR_W = 8
) (
  // Clock.
  input wire logic pclk,
  // Request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // Answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  // The bus is idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
  end
  // One transfer; the request is held until pready is sampled high.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The slave may stall; only the bench timeout ends this wait.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking testbench for the dual mode compare timer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // Clock, reset and pin stimulus.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic watch_tick = 1'b0;
  logic event_pin = 1'b0;
  // Bus and outputs.
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic toggle_pin_hi, toggle_pin_lo, irq_hi, irq_lo, rd_err;
  logic [7:0] first;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_irq_hi = 0;
  int n_irq_lo = 0;
  int cycles = 0;
  int n;

  always #25 pclk = ~pclk;

  apb_cpu_model #(.ADDR_W(8)) u_apb_cpu_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  dual_mode_compare_timer #(.ADDR_W(8)) u_dual_mode_compare_timer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watch_tick(watch_tick), .event_pin(event_pin), .toggle_pin_hi(toggle_pin_hi),
    .toggle_pin_lo(toggle_pin_lo), .irq_hi(irq_hi), .irq_lo(irq_lo));

  ////////////////////////////////////////////////////////////////////////////
  // Count request pulses and cut a hang short; the whole run needs ~250 cycles.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    n_irq_hi <= n_irq_hi + (irq_hi === 1'b1);
    n_irq_lo <= n_irq_lo + (irq_lo === 1'b1);
    if (cycles == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_apb_cpu_model.xfer(1'b1, a, {24'h000000, d}, rd_data, rd_err);
    // Pins launched at the access edge are only settled after it, so checks wait here.
    @(negedge pclk);
  endtask
  // Read with no check, for values that the calling scenario judges itself.
  task automatic peek(input logic [7:0] a);
    u_apb_cpu_model.xfer(1'b0, a, 32'h00000000, rd_data, rd_err);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    u_apb_cpu_model.xfer(1'b0, a, 32'h00000000, rd_data, rd_err);
    chk(name, {24'h000000, exp}, rd_data);
  endtask
  // Each level is held three clocks so no edge is lost; falling edges count.
  task automatic ev(input int k);
    repeat (k) begin
      @(posedge pclk);
      event_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      event_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'h00, "count_hi");
    rd(cmp_timer_pkg::OFS_COUNT_LO, 8'h00, "count_lo");
    rd(cmp_timer_pkg::OFS_COMPARE_HI, cmp_timer_pkg::RST_COMPARE[15:8], "cmp_hi");
    rd(cmp_timer_pkg::OFS_COMPARE_LO, cmp_timer_pkg::RST_COMPARE[7:0], "cmp_lo");
    rd(cmp_timer_pkg::OFS_CLOCK_CTRL, cmp_timer_pkg::RST_CTRL, "clock_ctrl");
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, cmp_timer_pkg::RST_FLAG, "flag_ctrl");
    rd(8'h1C, 8'h00, "unmapped");
    chk("pslverr", 32'h00000001, {31'h0, rd_err});
  endtask
  // Counter is stopped: external source selected and the event pin idle.
  task automatic t_count_rw();
    wr(cmp_timer_pkg::OFS_COUNT_HI, 8'hAA);
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'h00, "count_hi kept");
    wr(cmp_timer_pkg::OFS_COUNT_HI, 8'hAA);
    wr(cmp_timer_pkg::OFS_COUNT_LO, 8'h55);
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'hAA, "count_hi live");
    ev(1);
    rd(cmp_timer_pkg::OFS_COMPARE_LO, 8'hFF, "cmp_lo direct");
    rd(cmp_timer_pkg::OFS_COUNT_LO, 8'h55, "count_lo latched");
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'hAA, "count_hi");
    rd(cmp_timer_pkg::OFS_COUNT_LO, 8'h56, "count_lo counted");
  endtask
  task automatic t_match16();
    wr(cmp_timer_pkg::OFS_CLOCK_CTRL, 8'h80);
    chk("toggle_pin_hi set", 32'h1, {31'h0, toggle_pin_hi});
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h10);
    wr(cmp_timer_pkg::OFS_CONFIG, 8'h01);
    wr(cmp_timer_pkg::OFS_COMPARE_HI, 8'h00);
    wr(cmp_timer_pkg::OFS_COMPARE_LO, 8'h03);
    wr(cmp_timer_pkg::OFS_COUNT_HI, 8'h00);
    wr(cmp_timer_pkg::OFS_COUNT_LO, 8'h00);
    ev(3);
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h10, "no early match");
    n = n_irq_hi;
    ev(1);
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h54, "match flags");
    chk("toggle_pin_hi", 32'h0, {31'h0, toggle_pin_hi});
    chk("irq_hi", n + 1, n_irq_hi);
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'h00, "count_hi clr");
    rd(cmp_timer_pkg::OFS_COUNT_LO, 8'h00, "count_lo clr");
  endtask
  task automatic t_flags();
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'hDC);
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h10);
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h54, "flags kept");
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h10);
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h10, "flags cleared");
  endtask
  task automatic t_wrap16();
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h20);
    wr(cmp_timer_pkg::OFS_COUNT_HI, 8'hFF);
    wr(cmp_timer_pkg::OFS_COUNT_LO, 8'hFF);
    n = n_irq_hi;
    ev(1);
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'hA8, "wrap flags");
    rd(cmp_timer_pkg::OFS_COUNT_HI, 8'h00, "count_hi wrap");
    chk("irq_hi wrap", n + 1, n_irq_hi);
  endtask
  // Split mode: high half on the divided clock, low half on events.
  task automatic t_split8();
    wr(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h01);
    wr(cmp_timer_pkg::OFS_CONFIG, 8'h03);
    wr(cmp_timer_pkg::OFS_CLOCK_CTRL, 8'h60);
    chk("toggle_pin_lo set", 32'h0, {31'h0, toggle_pin_lo});
    wr(cmp_timer_pkg::OFS_COUNT_LO, 8'h00);
    wr(cmp_timer_pkg::OFS_COMPARE_LO, 8'h02);
    n = n_irq_lo;
    ev(3);
    rd(cmp_timer_pkg::OFS_COUNT_LO, 8'h00, "count_lo clr");
    chk("toggle_pin_lo", 32'h1, {31'h0, toggle_pin_lo});
    chk("irq_lo", n + 1, n_irq_lo);
    // The high half left zero on its first tick, so its match flag is up as well.
    rd(cmp_timer_pkg::OFS_FLAG_CTRL, 8'h45, "flags split");
    chk("flags lo", 32'h05, rd_data & 32'h0F);
    chk("toggle_pin_hi split", 32'h1, {31'h0, toggle_pin_hi});
    peek(cmp_timer_pkg::OFS_COUNT_HI);
    chk("pslverr mapped", 32'h0, {31'h0, rd_err});
    first = rd_data[7:0];
    repeat (20) @(posedge pclk);
    peek(cmp_timer_pkg::OFS_COUNT_HI);
    num_checks++;
    if ((rd_data[7:0] === first) || $isunknown(rd_data)) begin
      n_mismatch++;
      $display("ERROR count_hi expected change seen %h", rd_data);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count_rw();
    t_match16();
    t_flags();
    t_wrap16();
    t_split8();
    end_sim();
  end
endmodule
`default_nettype wire
